// >>> common/lane_if.sv
// controller to lane serializer connection
`timescale 1ns/10ps
`default_nettype none
interface lane_if;
   logic       ce;
   logic       load;
   logic       shift;
   logic [7:0] byte_in;
   logic       bit_out;
   modport ctl  (output ce, load, shift, byte_in, input bit_out);
   modport lane (input ce, load, shift, byte_in, output bit_out);
endinterface
`default_nettype wire

// >>> common/qadc_pkg.sv
// shared constants and types of the quad converter serial output block
`default_nettype none
package qadc_pkg;
   // timing: system clock, nominal sample clock, derived counts
   localparam int         HCLK_NS      = 10;
   localparam int         SCLK_NS      = 80;
   localparam logic [3:0] PER_CYC      = 4'(SCLK_NS / HCLK_NS);
   localparam logic [3:0] PER_LAST     = PER_CYC - 4'h1;
   localparam logic [3:0] PER_SAT      = 4'hf;
   localparam logic [6:0] LOCK_PERIODS = 7'h64;
   localparam logic [2:0] HALF_BYTE    = 3'h4;

   // widths
   localparam int LANES = 4;
   localparam int NSYNC = 8;

   // data coding
   localparam logic [7:0] MSB_FLIP  = 8'h80;
   localparam logic [7:0] TEST_BYTE = 8'hc0;
   localparam logic [3:0] PAIR_MAP  = 4'hc;

   // register offsets
   localparam logic [7:0] OFF_STATUS  = 8'h00;
   localparam logic [7:0] OFF_IRQ_EN  = 8'h04;
   localparam logic [7:0] OFF_IRQ_CLR = 8'h08;
   localparam logic [7:0] OFF_CTRL    = 8'h0c;
   localparam logic [7:0] OFF_STATE   = 8'h10;

   // field positions
   localparam int EV_LOSS   = 0;
   localparam int EV_RELOCK = 1;
   localparam int CTRL_TP   = 0;
   localparam int ST_LOCK   = 0;
   localparam int ST_STBY   = 1;
   localparam int ST_TWOS   = 2;
   localparam int ST_TEST   = 3;
   localparam int ST_REF    = 4;
   localparam int ST_SHARED = 6;
   localparam int ST_STABLE = 8;

   // reset values
   localparam logic [1:0] RST_IRQ_EN = 2'h0;
   localparam logic       RST_CTRL   = 1'h0;
   localparam logic       RST_LOCK_N = 1'h1;

   typedef enum logic [1:0] {
      REF_1V0  = 2'h0,
      REF_0V5  = 2'h1,
      REF_PROG = 2'h2,
      REF_EXT  = 2'h3
   } ref_mode_t;
endpackage
`default_nettype wire

// >>> hw/lane_ser.sv
// one serial lane: loads a byte and shifts it out msb first
`timescale 1ns/10ps
`default_nettype none
module lane_ser (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control from the frame logic
   lane_if.lane     lk
);
   typedef struct packed {
      logic [7:0] sh;
   } lane_t;
   lane_t st;
   lane_t next_st;

   always_comb begin
      next_st = st;
      if (lk.load) begin
         next_st.sh = lk.byte_in;
      end else if (lk.shift) begin
         next_st.sh = {st.sh[6:0], 1'b0};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else if (lk.ce) begin
         st <= next_st;
      end
   end

   assign lk.bit_out = st.sh[7];

   lane_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
      lk.ce && lk.load |=> lk.bit_out == $past(lk.byte_in[7]))
      else $error("lane did not present the loaded msb");
endmodule // lane_ser
`default_nettype wire

// >>> hw/pin_sync.sv
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         ce,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t st;
   sync_t next_st;

   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign q = st.s2;
endmodule // pin_sync
`default_nettype wire

// >>> hw/qadc_out.sv
// serial output side of the quad converter: framing, lock, modes, ahb regs
//
// How it works
// - format pin high gives twos complement, low gives offset binary
// - twos complement is the offset binary code with msb inverted
// - each channel shifts its 8-bit sample onto its own lane
// - bit clock runs at four times the sample clock
// - one bit per bit clock edge, receiver captures on both edges
// - frame clock rises on the first bit of every byte
// - active-low lock output is low while locked
// - lock output goes high at once when lock is lost
// - unlocked: lanes and bit clock hold their last levels
// - relock needs at least 100 good sample periods
// - first frame edge 0.5 to under 1.5 periods after lock falls
// - test pattern pin makes every lane send 11000000
// - sense level decodes into four reference modes
// - shared reference pin enables sharing; a,b on pair a, c,d on pair b
// - standby pin high puts serial drivers in high impedance
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module qadc_out (
   // clock, reset, enable
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             irq,
   // sample clock and converter words, lane a in bits 7:0
   input  wire logic        sample_clk,
   input  wire logic [31:0] sample_data,
   // strap and mode pins
   input  wire logic        format_select_pin,
   input  wire logic        test_pattern_pin,
   input  wire logic        standby_pin,
   input  wire logic        shared_ref_pin,
   input  wire logic        sense_low,
   input  wire logic        sense_vref,
   input  wire logic        sense_supply,
   // serial link
   output logic [3:0]       lane_out,
   output logic             bit_clock_out,
   output logic             frame_clock_out,
   output logic             link_oe,
   output logic             lock_n,
   // reference control
   output logic [1:0]       ref_mode,
   output logic             shared_ref_en,
   output logic [3:0]       ref_pair_sel
);
   typedef enum logic [2:0] {
      S_UNLOCK = 3'h1,
      S_WAIT   = 3'h2,
      S_RUN    = 3'h4
   } fsm_t;

   typedef struct packed {
      fsm_t        fsm;
      logic        sclk_d;
      logic [3:0]  per_cnt;
      logic [6:0]  stable;
      logic [2:0]  bit_idx;
      logic        lock_n;
      logic        bclk;
      logic        frame;
      logic        oe;
      logic [1:0]  status;
      logic [1:0]  irq_en;
      logic        ctrl_tp;
      logic        irq;
      logic        ap_wr;
      logic [7:0]  ap_addr;
      logic [31:0] rdata;
      logic [1:0]  ref_mode;
      logic        shared;
   } core_t;

   core_t st;
   core_t next_st;

   // synchronised pins
   logic [7:0] pins;
   logic       sclk_s;
   logic       fmt_s;
   logic       tp_s;
   logic       stby_s;
   logic       shr_s;
   logic       slow_s;
   logic       svref_s;
   logic       ssup_s;

   pin_sync #(
      .W (qadc_pkg::NSYNC)
   ) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .d       ({sense_supply, sense_vref, sense_low, shared_ref_pin,
                 standby_pin, test_pattern_pin, format_select_pin,
                 sample_clk}),
      .q       (pins)
   );

   assign sclk_s  = pins[0];
   assign fmt_s   = pins[1];
   assign tp_s    = pins[2];
   assign stby_s  = pins[3];
   assign shr_s   = pins[4];
   assign slow_s  = pins[5];
   assign svref_s = pins[6];
   assign ssup_s  = pins[7];

   // edge finder and pll lock model
   logic rise;
   logic good_edge;
   logic bad_edge;
   logic load;
   logic shift;
   logic test_on;

   assign rise      = sclk_s & ~st.sclk_d;
   assign good_edge = rise & (st.per_cnt == qadc_pkg::PER_LAST);
   // a slow, fast or missing sample edge, or standby, counts as loss
   assign bad_edge  = (rise & ~good_edge) |
                      (st.per_cnt > qadc_pkg::PER_CYC) | stby_s;
   assign load      = rise & ~bad_edge & (st.fsm != S_UNLOCK);
   assign shift     = (st.fsm == S_RUN) & ~rise & ~bad_edge &
                      (st.bit_idx != 3'h0);
   assign test_on   = tp_s | st.ctrl_tp;

   // per lane byte coding
   logic [7:0] lane_byte [qadc_pkg::LANES];
   logic [3:0] lane_bits;

   always_comb begin
      for (int i = 0; i < qadc_pkg::LANES; i++) begin
         if (test_on) begin
            lane_byte[i] = qadc_pkg::TEST_BYTE;
         end else if (fmt_s) begin
            lane_byte[i] = sample_data[8*i +: 8] ^ qadc_pkg::MSB_FLIP;
         end else begin
            lane_byte[i] = sample_data[8*i +: 8];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < qadc_pkg::LANES; g++) begin : g_lane
         lane_if lif ();
         assign lif.ce      = ce;
         assign lif.load    = load;
         assign lif.shift   = shift;
         assign lif.byte_in = lane_byte[g];
         assign lane_bits[g] = lif.bit_out;
         lane_ser u_lane (
            .hclk    (hclk),
            .hresetn (hresetn),
            .lk      (lif.lane)
         );
      end
   endgenerate

   // bus decode
   logic       acc;
   logic [1:0] ev;
   logic [1:0] clr;

   assign acc = hsel & hready & htrans[1];

   always_comb begin
      next_st = st;
      ev      = 2'h0;
      clr     = 2'h0;

      next_st.sclk_d = sclk_s;
      if (rise) begin
         next_st.per_cnt = 4'h0;
      end else if (st.per_cnt != qadc_pkg::PER_SAT) begin
         next_st.per_cnt = st.per_cnt + 4'h1;
      end

      if (bad_edge) begin
         next_st.stable = 7'h0;
      end else if (good_edge && st.stable != qadc_pkg::LOCK_PERIODS) begin
         next_st.stable = st.stable + 7'h1;
      end

      case (st.fsm)
         S_UNLOCK: begin
            if (good_edge && !bad_edge &&
                st.stable == qadc_pkg::LOCK_PERIODS - 7'h1) begin
               next_st.fsm    = S_WAIT;
               next_st.lock_n = 1'b0;
               next_st.frame  = 1'b0;
               ev[qadc_pkg::EV_RELOCK] = 1'b1;
            end
         end
         S_WAIT, S_RUN: begin
            if (bad_edge) begin
               next_st.fsm    = S_UNLOCK;
               next_st.lock_n = 1'b1;
               ev[qadc_pkg::EV_LOSS] = 1'b1;
            end else if (load) begin
               next_st.fsm = S_RUN;
            end
         end
         default: begin
            next_st.fsm    = S_UNLOCK;
            next_st.lock_n = 1'b1;
         end
      endcase

      // unlocked: no load and no shift, so lanes and bit clock hold
      if (load) begin
         next_st.bit_idx = 3'h1;
         next_st.frame   = 1'b1;
         next_st.bclk    = ~st.bclk;
      end else if (shift) begin
         next_st.bit_idx = st.bit_idx + 3'h1;
         next_st.frame   = st.bit_idx < qadc_pkg::HALF_BYTE;
         next_st.bclk    = ~st.bclk;
      end

      next_st.oe = ~stby_s;

      if (ssup_s) begin
         next_st.ref_mode = qadc_pkg::REF_EXT;
      end else if (svref_s) begin
         next_st.ref_mode = qadc_pkg::REF_0V5;
      end else if (slow_s) begin
         next_st.ref_mode = qadc_pkg::REF_1V0;
      end else begin
         next_st.ref_mode = qadc_pkg::REF_PROG;
      end
      next_st.shared = shr_s;

      // data phase write
      if (st.ap_wr) begin
         case (st.ap_addr)
            qadc_pkg::OFF_IRQ_EN:  next_st.irq_en = hwdata[1:0];
            qadc_pkg::OFF_IRQ_CLR: clr = hwdata[1:0];
            qadc_pkg::OFF_CTRL:    next_st.ctrl_tp = hwdata[qadc_pkg::CTRL_TP];
            default:               next_st.irq_en = st.irq_en;
         endcase
      end

      // a new event wins over a clear in the same cycle
      next_st.status = (st.status & ~clr) | ev;
      next_st.irq    = |(next_st.status & next_st.irq_en);

      // address phase; read data built from the values now being stored
      next_st.ap_wr   = acc & hwrite;
      next_st.ap_addr = haddr[7:0];
      if (acc && !hwrite) begin
         next_st.rdata = 32'h0;
         case (haddr[7:0])
            qadc_pkg::OFF_STATUS: next_st.rdata[1:0] = next_st.status;
            qadc_pkg::OFF_IRQ_EN: next_st.rdata[1:0] = next_st.irq_en;
            qadc_pkg::OFF_CTRL:
               next_st.rdata[qadc_pkg::CTRL_TP] = next_st.ctrl_tp;
            qadc_pkg::OFF_STATE: begin
               next_st.rdata[qadc_pkg::ST_LOCK]   = ~next_st.lock_n;
               next_st.rdata[qadc_pkg::ST_STBY]   = ~next_st.oe;
               next_st.rdata[qadc_pkg::ST_TWOS]   = fmt_s;
               next_st.rdata[qadc_pkg::ST_TEST]   = test_on;
               next_st.rdata[qadc_pkg::ST_REF +: 2] = next_st.ref_mode;
               next_st.rdata[qadc_pkg::ST_SHARED] = next_st.shared;
               next_st.rdata[qadc_pkg::ST_STABLE +: 7] = next_st.stable;
            end
            default: next_st.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st         <= '0;
         st.fsm     <= S_UNLOCK;
         st.lock_n  <= qadc_pkg::RST_LOCK_N;
         st.irq_en  <= qadc_pkg::RST_IRQ_EN;
         st.ctrl_tp <= qadc_pkg::RST_CTRL;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // outputs
   assign hreadyout       = 1'b1;
   assign hresp           = 1'b0;
   assign hrdata          = st.rdata;
   assign irq             = st.irq;
   assign lane_out        = lane_bits;
   assign bit_clock_out   = st.bclk;
   assign frame_clock_out = st.frame;
   assign link_oe         = st.oe;
   assign lock_n          = st.lock_n;
   assign ref_mode        = st.ref_mode;
   assign shared_ref_en   = st.shared;
   assign ref_pair_sel    = qadc_pkg::PAIR_MAP;

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_lock_fall;
      $fell(lock_n);
   endsequence

   sequence s_frame_start;
      ce && load;
   endsequence

   fmt_code_a: assert property (
      load && !test_on |-> lane_byte[0] ==
         (sample_data[7:0] ^ (fmt_s ? qadc_pkg::MSB_FLIP : 8'h00)))
      else $error("lane a coding does not follow the format pin");

   test_byte_a: assert property (
      load && test_on |-> lane_byte[3] == qadc_pkg::TEST_BYTE)
      else $error("test pattern byte is wrong");

   frame_len_a: assert property (
      s_frame_start |=> frame_clock_out[*4] ##1
         (!frame_clock_out || lock_n))
      else $error("frame clock not high for half a byte");

   bclk_run_a: assert property (
      s_frame_start |=> $changed(bit_clock_out) ##1
         ($changed(bit_clock_out) || lock_n || !ce)[*7])
      else $error("bit clock missed a toggle inside a byte");

   lock_low_a: assert property (
      lock_n == (st.fsm == S_UNLOCK))
      else $error("lock output disagrees with lock state");

   loss_fast_a: assert property (
      ce && bad_edge && st.fsm != S_UNLOCK |=> lock_n)
      else $error("lock output late after loss");

   freeze_a: assert property (
      lock_n ##1 lock_n |-> $stable(bit_clock_out) && $stable(lane_out))
      else $error("link moved while unlocked");

   relock_min_a: assert property (
      s_lock_fall |-> st.stable == qadc_pkg::LOCK_PERIODS)
      else $error("lock reported before 100 good periods");

   first_frame_a: assert property (
      s_lock_fall |-> ##[4:11] ($rose(frame_clock_out) || lock_n))
      else $error("first frame edge outside its window");

   standby_hiz_a: assert property (
      ce && stby_s |=> !link_oe && lock_n)
      else $error("drivers enabled in standby");

   ref_decode_a: assert property (
      ce && ssup_s |=> ref_mode == qadc_pkg::REF_EXT)
      else $error("supply sense did not select external reference");
endmodule // qadc_out
`default_nettype wire

// >>> tb/qadc_rx.sv
// receiver model: double data rate lane capture and byte assembly
`timescale 1ns/10ps
`default_nettype none
module qadc_rx (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // serial link
   input  wire logic [3:0]  lane_out,
   input  wire logic        bit_clock_out,
   input  wire logic        frame_clock_out,
   input  wire logic        lock_n,
   // assembled bytes, lane a in bits 7:0
   output logic [31:0]      rx_byte,
   output logic             rx_stb
);
   logic        bc_q;
   logic        fr_q;
   logic [3:0]  cnt;
   logic [3:0]  cnt_n;
   logic [31:0] sh;
   logic [31:0] nsh;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         nsh[i*8 +: 8] = {sh[i*8 +: 7], lane_out[i]};
      end
      cnt_n = (frame_clock_out && !fr_q) ? 4'h1 :
              (cnt == 4'h0) ? 4'h0 : cnt + 4'h1;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bc_q <= 1'b0;
         fr_q <= 1'b0;
         cnt <= 4'h0;
         sh <= 32'h0;
         rx_byte <= 32'h0;
         rx_stb <= 1'b0;
      end else begin
         bc_q <= bit_clock_out;
         fr_q <= frame_clock_out;
         rx_stb <= 1'b0;
         if (lock_n) begin
            cnt <= 4'h0;
         end else if (bit_clock_out != bc_q) begin
            sh <= nsh;
            cnt <= (cnt_n == 4'h8) ? 4'h0 : cnt_n;
            if (cnt_n == 4'h8) begin
               rx_byte <= nsh;
               rx_stb <= 1'b1;
            end
         end
      end
   end
endmodule // qadc_rx
`default_nettype wire

// >>> tb/tb_quad_adc_serial_output.sv
// self-checking bench of the quad converter serial output block
`timescale 1ns/10ps
`default_nettype none
module tb_quad_adc_serial_output;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        sample_clk = 1'b0;
   logic        sc_run = 1'b0;
   logic [31:0] sample_data = 32'h0;
   logic [6:0]  pins = 7'h0; // format,test,standby,shared,low,vref,supply
   logic        hready, hresp, irq, bit_clock_out, frame_clock_out;
   logic        link_oe, lock_n, shared_ref_en, rx_stb, fr_d, bc_d;
   logic [31:0] hrdata, rx_byte, rd;
   logic [3:0]  lane_out, ref_pair_sel, snap_l;
   logic [1:0]  ref_mode;
   logic        snap_b;
   int          fails = 0;
   int          comparisons = 0;
   int          n, t, p, tog;
   localparam logic [7:0] REF_EXP = 8'hd2;
   // locked, full count, shared, external reference, offset binary
   localparam logic [31:0] STATE_EXP = {17'h0, qadc_pkg::LOCK_PERIODS,
                                        2'h1, qadc_pkg::REF_EXT, 4'h1};

   always #5 hclk = ~hclk;
   // sample clock, eight hclk periods long, offset 3.3 ns from the hclk edges
   initial begin
      #3.3;
      forever #40 if (sc_run) sample_clk = ~sample_clk;
   end
   always @(posedge hclk) begin
      fr_d <= frame_clock_out;
      bc_d <= bit_clock_out;
   end

   qadc_out qadc_out_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .irq(irq), .sample_clk(sample_clk),
      .sample_data(sample_data), .format_select_pin(pins[6]),
      .test_pattern_pin(pins[5]), .standby_pin(pins[4]),
      .shared_ref_pin(pins[3]), .sense_low(pins[2]), .sense_vref(pins[1]),
      .sense_supply(pins[0]), .lane_out(lane_out),
      .bit_clock_out(bit_clock_out), .frame_clock_out(frame_clock_out),
      .link_oe(link_oe), .lock_n(lock_n), .ref_mode(ref_mode),
      .shared_ref_en(shared_ref_en), .ref_pair_sel(ref_pair_sel));
   qadc_rx qadc_rx_i (.hclk(hclk), .hresetn(hresetn), .lane_out(lane_out),
      .bit_clock_out(bit_clock_out), .frame_clock_out(frame_clock_out),
      .lock_n(lock_n), .rx_byte(rx_byte), .rx_stb(rx_stb));

   task print_verdict();
      if (fails == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   function automatic logic [7:0] model(int v, int twos, int tp);
      int r;
      r = tp ? 192 : (twos ? (v + 128) % 256 : v);
      return 8'(r);
   endfunction
   function automatic logic fr_rise();
      return frame_clock_out === 1'b1 && fr_d === 1'b0;
   endfunction
   task frame_per();
      p = 0;
      tog = 0;
      do begin
         @(posedge hclk);
         p++;
         if (bit_clock_out !== bc_d) tog++;
      end while (!fr_rise() && p < 40);
      chk(p, 8);
      chk(tog, 8);
   endtask
   task lock_up();
      sc_run = 1'b1;
      t = 0;
      while (lock_n !== 1'b0 && t < 2000) begin
         @(posedge hclk);
         t++;
      end
      chk(t >= 800 && t < 2000, 1'b1);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (!fr_rise() && n < 40);
      chk(n >= 4 && n < 12, 1'b1);
      frame_per();
   endtask
   task data_check(input int twos, input int tp);
      logic [31:0] d;
      d = $urandom;
      sample_data <= d;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge hclk);
            n++;
         end while (rx_stb !== 1'b1 && n < 40);
      end
      for (int i = 0; i < 4; i++) begin
         chk(rx_byte[i*8 +: 8], model(d[i*8 +: 8], twos, tp));
      end
   endtask
   task loss_wait();
      sc_run = 1'b0;
      t = 0;
      while (lock_n !== 1'b1 && t < 40) begin
         @(posedge hclk);
         t++;
      end
      chk(t < 30, 1'b1);
   endtask

   initial begin
      #400us;
      fails++;
      print_verdict();
   end

   initial begin
      void'($urandom(6047));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(lock_n, 1'b1);
      chk(hresp, 1'b0);
      bus(1'b0, qadc_pkg::OFF_IRQ_EN, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, qadc_pkg::OFF_CTRL, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      for (int k = 0; k < 4; k++) begin
         pins[3:0] <= {k[0], (k == 0) ? 3'h0 : 3'(4'h8 >> k)};
         repeat (6) @(posedge hclk);
         chk(ref_mode, REF_EXP[k*2 +: 2]);
         chk(shared_ref_en, k[0]);
         chk(ref_pair_sel, 4'hc);
      end
      lock_up();
      chk(lock_n, 1'b0);
      chk(link_oe, 1'b1);
      bus(1'b0, qadc_pkg::OFF_STATE, 32'h0);
      chk(rd, STATE_EXP);
      for (int f = 0; f < 2; f++) begin
         pins[6] <= f[0];
         repeat (6) @(posedge hclk);
         repeat (3) data_check(f, 0);
      end
      pins[5] <= 1'b1;
      repeat (6) @(posedge hclk);
      data_check(1, 1);
      frame_per();
      pins[5] <= 1'b0;
      bus(1'b1, qadc_pkg::OFF_CTRL, 32'h1);
      data_check(1, 1);
      bus(1'b1, qadc_pkg::OFF_CTRL, 32'h0);
      data_check(1, 0);
      bus(1'b1, qadc_pkg::OFF_IRQ_EN, 32'h1);
      loss_wait();
      snap_l = lane_out;
      snap_b = bit_clock_out;
      repeat (40) @(posedge hclk);
      chk(lane_out, snap_l);
      chk(bit_clock_out, snap_b);
      chk(irq, 1'b1);
      bus(1'b0, qadc_pkg::OFF_STATUS, 32'h0);
      chk(rd[1:0], 2'h3);
      bus(1'b1, qadc_pkg::OFF_IRQ_CLR, 32'h1);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b0);
      lock_up();
      data_check(1, 0);
      chk(irq, 1'b0);
      bus(1'b0, qadc_pkg::OFF_STATUS, 32'h0);
      chk(rd[1:0], 2'h2);
      bus(1'b1, qadc_pkg::OFF_IRQ_EN, 32'h3);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b1);
      bus(1'b1, qadc_pkg::OFF_IRQ_CLR, 32'h3);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b0);
      pins[4] <= 1'b1;
      repeat (8) @(posedge hclk);
      chk(link_oe, 1'b0);
      chk(lock_n, 1'b1);
      // stop the clock too, so relock counts from a fresh first edge
      sc_run = 1'b0;
      repeat (16) @(posedge hclk);
      pins[4] <= 1'b0;
      lock_up();
      chk(link_oe, 1'b1);
      print_verdict();
   end
endmodule // tb_quad_adc_serial_output
`default_nettype wire
